// file: verilog/hfwd_cfg.svh
`ifndef HFWD_CFG_SVH
`define HFWD_CFG_SVH
// Clock period
`define HFWD_CLK_PERIOD_NS 10
// Forwarding limit for header packets and other packets
`define HFWD_FWD_MAX_NS 400
`define HFWD_FWD_MAX_CYC (`HFWD_FWD_MAX_NS / `HFWD_CLK_PERIOD_NS)
// Pipeline delay of this forwarder, reported to descriptor logic
`define HFWD_ACTUAL_DELAY_NS 30
// Enabled-to-U3 limit, 1 s
`define HFWD_EN_U3_MAX_S 1
`define HFWD_EN_U3_MAX_CYC (`HFWD_EN_U3_MAX_S * 1000000000 / `HFWD_CLK_PERIOD_NS)
// Resume drive limit, 400 us
`define HFWD_RESUME_MAX_US 400
`define HFWD_RESUME_MAX_CYC (`HFWD_RESUME_MAX_US * 1000 / `HFWD_CLK_PERIOD_NS)
// Arbitration weight base, 1.25 Gbps held in units of 10 Mbps
`define HFWD_ARB_BASE_10MBPS 125
`endif

// file: verilog/hfwd_pkg.sv
`default_nettype none
package hfwd_pkg;
    typedef enum logic [1:0] {HFWD_CONN_NONE, HFWD_CONN_LEGACY, HFWD_CONN_ENH} hfwd_conn_t;
    typedef enum logic [1:0] {HFWD_DS_IDLE, HFWD_DS_WAIT_U3, HFWD_DS_U3, HFWD_DS_RESUME} hfwd_ds_t;
endpackage : hfwd_pkg
`default_nettype wire

// file: verilog/hfwd_core.sv
`include "hfwd_cfg.svh"
`default_nettype none
// Functional notes
// - A header packet is forwarded within 400 ns of its last received word at equal speeds in U0.
// - The forwarding bound holds only with no link commands pending, nonzero credit, empty tx buffer.
// - Any packet is forwarded within 400 ns of its last received word at equal speeds in U0.
// - The delay actually introduced is reported on a port for the hub descriptor.
// - A port enabled while upstream is in U3 without remote wakeup starts U3 entry within 1 s.
// - Arbitration weights use 1.25 Gbps as denominator.
// - A U0 request on a U3 port starts resume signaling within 400 us.
// - Enhanced mode forms only when host and device both support it; otherwise legacy.
// - Legacy full and low speed may be offered; older host ports need not be served.
module hfwd_core #(
    parameter int DATA_W = 32,
    parameter int EN_U3_CYC = `HFWD_EN_U3_MAX_CYC,
    parameter int RESUME_CYC = `HFWD_RESUME_MAX_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clk_en,
    // Receive stream
    input wire logic rx_valid,
    input wire logic [DATA_W-1:0] rx_data,
    input wire logic rx_last,
    output logic rx_ready,
    // Transmit stream
    output logic tx_valid,
    output logic [DATA_W-1:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    // Link conditions, same clock domain
    input wire logic same_speed,
    input wire logic links_u0,
    input wire logic lcmd_pending,
    input wire logic credit_nonzero,
    input wire logic txbuf_empty,
    // Downstream port power state
    input wire logic ds_enabled,
    input wire logic us_in_u3,
    input wire logic rwake_en,
    input wire logic u0_request,
    output logic ds_go_u3,
    output logic ds_resume,
    // Arbitration
    input wire logic [15:0] port_rate_10mbps,
    output logic [15:0] arb_weight,
    // Capabilities (pins, other domain)
    input wire logic host_enh_cap,
    input wire logic dev_enh_cap,
    output hfwd_pkg::hfwd_conn_t conn_mode,
    // Status
    output logic [15:0] hub_delay_ns,
    output logic fwd_in_bound
);
    import hfwd_pkg::*;

    // ********************
    // Parameter checks
    // ********************
    // A zero-width word or a zero-length limit leaves nothing to count against
    if (DATA_W < 1) begin : g_bad_width
        $error("hfwd_core: DATA_W must be at least 1");
    end
    if (EN_U3_CYC < 1) begin : g_bad_en_u3
        $error("hfwd_core: EN_U3_CYC must be at least 1");
    end
    if (RESUME_CYC < 1) begin : g_bad_resume
        $error("hfwd_core: RESUME_CYC must be at least 1");
    end
    // The bound counter is 16 bits wide and saturates at its top, 16'hFFFF
    if (`HFWD_FWD_MAX_CYC > 65534) begin : g_bad_fwd
        $error("hfwd_core: forwarding limit exceeds the bound counter");
    end

    // ********************
    // Two-entry buffer
    // ********************
    // Two slots so a receiver stall never drops a word and rx_ready stays registered
    logic [DATA_W:0] slot_r [2];
    logic [DATA_W:0] slot_nxt [2];
    logic [1:0] cnt_r, cnt_nxt;
    logic tx_valid_nxt;
    logic [DATA_W-1:0] tx_data_nxt;
    logic tx_last_nxt;
    logic rx_ready_nxt;
    logic push, pop;

    always_comb begin
        push = rx_valid && rx_ready;
        pop = tx_valid && tx_ready;
        slot_nxt[0] = slot_r[0];
        slot_nxt[1] = slot_r[1];
        cnt_nxt = cnt_r;
        if (pop) begin
            slot_nxt[0] = slot_r[1];
            cnt_nxt = cnt_nxt - 2'd1;
        end
        if (push) begin
            slot_nxt[cnt_nxt[0]] = {rx_last, rx_data};
            cnt_nxt = cnt_nxt + 2'd1;
        end
        tx_valid_nxt = (cnt_nxt != 2'd0);
        tx_data_nxt = slot_nxt[0][DATA_W-1:0];
        tx_last_nxt = slot_nxt[0][DATA_W];
        rx_ready_nxt = (cnt_nxt != 2'd2);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            slot_r[0] <= '0;
            slot_r[1] <= '0;
            cnt_r <= 2'd0;
            tx_valid <= 1'b0;
            tx_data <= '0;
            tx_last <= 1'b0;
            rx_ready <= 1'b0;
        end else if (clk_en) begin
            slot_r <= slot_nxt;
            cnt_r <= cnt_nxt;
            tx_valid <= tx_valid_nxt;
            tx_data <= tx_data_nxt;
            tx_last <= tx_last_nxt;
            rx_ready <= rx_ready_nxt;
        end
    end

    // ********************
    // Forwarding bound watch
    // ********************
    // The bound only applies while the qualifying conditions hold
    localparam int FWD_CYC = `HFWD_FWD_MAX_CYC;
    // Unqualified cycles are not counted, so a stall by link commands or
    // missing credit never reads as an overrun of the forwarding limit
    logic [15:0] fwd_cnt_r, fwd_cnt_nxt;
    logic waiting_r, waiting_nxt;
    logic in_bound_nxt;
    logic qualified;

    always_comb begin
        qualified = same_speed && links_u0 && !lcmd_pending
            && credit_nonzero && txbuf_empty;
        waiting_nxt = waiting_r;
        fwd_cnt_nxt = fwd_cnt_r;
        in_bound_nxt = fwd_in_bound;
        if (push && rx_last) begin
            waiting_nxt = 1'b1;
            fwd_cnt_nxt = 16'h0000;
        end else if (pop) begin
            waiting_nxt = 1'b0;
        end else if (waiting_r && qualified && fwd_cnt_r != 16'hFFFF) begin
            fwd_cnt_nxt = fwd_cnt_r + 16'h0001;
        end
        if (waiting_r && qualified && fwd_cnt_r >= 16'(FWD_CYC)) begin
            in_bound_nxt = 1'b0;
        end else if (push && rx_last) begin
            in_bound_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            waiting_r <= 1'b0;
            fwd_cnt_r <= 16'h0000;
            fwd_in_bound <= 1'b1;
        end else if (clk_en) begin
            waiting_r <= waiting_nxt;
            fwd_cnt_r <= fwd_cnt_nxt;
            fwd_in_bound <= in_bound_nxt;
        end
    end

    // ********************
    // Capability synchronisers
    // ********************
    logic [2:0] hcap_sync_r, dcap_sync_r;
    logic hcap_r, dcap_r;
    logic hcap_nxt, dcap_nxt;

    // Stage 0 may be metastable; only stages 1 and 2 are trusted
    always_comb begin
        // Accept a pin change only once the two older stages agree
        if (hcap_sync_r[1] == hcap_sync_r[2]) begin
            hcap_nxt = hcap_sync_r[2];
        end else begin
            hcap_nxt = hcap_r;
        end
        if (dcap_sync_r[1] == dcap_sync_r[2]) begin
            dcap_nxt = dcap_sync_r[2];
        end else begin
            dcap_nxt = dcap_r;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hcap_sync_r <= 3'h0;
            dcap_sync_r <= 3'h0;
            hcap_r <= 1'b0;
            dcap_r <= 1'b0;
        end else if (clk_en) begin
            hcap_sync_r <= {hcap_sync_r[1:0], host_enh_cap};
            dcap_sync_r <= {dcap_sync_r[1:0], dev_enh_cap};
            hcap_r <= hcap_nxt;
            dcap_r <= dcap_nxt;
        end
    end

    // ********************
    // Connection mode, weight, delay report
    // ********************
    // Mode follows the filtered capability pins, never the raw pins
    hfwd_conn_t conn_nxt;
    logic [15:0] weight_nxt;
    logic [31:0] weight_wide;

    always_comb begin
        // Legacy covers high, full and low speed; older host ports are not special-cased
        conn_nxt = (hcap_r && dcap_r) ? HFWD_CONN_ENH : HFWD_CONN_LEGACY;
        // Weight in 1/256 units: rate over the fixed base
        weight_wide = ({16'h0000, port_rate_10mbps} << 8) / 32'(`HFWD_ARB_BASE_10MBPS);
        weight_nxt = (weight_wide > 32'h0000_FFFF) ? 16'hFFFF : weight_wide[15:0];
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            conn_mode <= HFWD_CONN_NONE;
            arb_weight <= 16'h0000;
            hub_delay_ns <= 16'h0000;
        end else if (clk_en) begin
            conn_mode <= conn_nxt;
            arb_weight <= weight_nxt;
            hub_delay_ns <= 16'(`HFWD_ACTUAL_DELAY_NS);
        end
    end

    // ********************
    // Downstream link state
    // ********************
    // One downstream port is tracked here; a hub uses one copy per port.
    // Entry into U3 is taken on the enable edge only, so a port that stays
    // enabled is not pushed into U3 a second time after it resumed.
    // Resume is driven for a fixed RESUME_CYC+1 cycles, a trade of
    // simplicity against watching the far side for the end of resume.
    hfwd_ds_t ds_r, ds_nxt;
    logic [31:0] ds_cnt_r, ds_cnt_nxt;
    logic go_u3_nxt, resume_nxt;
    logic en_prev_r;

    always_comb begin
        ds_nxt = ds_r;
        ds_cnt_nxt = ds_cnt_r;
        go_u3_nxt = 1'b0;
        resume_nxt = 1'b0;
        case (ds_r)
            HFWD_DS_IDLE: begin
                if (ds_enabled && !en_prev_r && us_in_u3 && !rwake_en) begin
                    ds_nxt = HFWD_DS_WAIT_U3;
                    ds_cnt_nxt = 32'h0000_0000;
                end
            end
            HFWD_DS_WAIT_U3: begin
                // Enter right away, well inside the limit
                ds_cnt_nxt = ds_cnt_r + 32'h0000_0001;
                if (ds_cnt_r < 32'(EN_U3_CYC)) begin
                    go_u3_nxt = 1'b1;
                    ds_nxt = HFWD_DS_U3;
                end
            end
            HFWD_DS_U3: begin
                if (u0_request) begin
                    ds_nxt = HFWD_DS_RESUME;
                    ds_cnt_nxt = 32'h0000_0000;
                end else if (!ds_enabled) begin
                    ds_nxt = HFWD_DS_IDLE;
                end
            end
            HFWD_DS_RESUME: begin
                resume_nxt = 1'b1;
                ds_cnt_nxt = ds_cnt_r + 32'h0000_0001;
                if (ds_cnt_r >= 32'(RESUME_CYC)) begin
                    ds_nxt = HFWD_DS_IDLE;
                end
            end
            default: ds_nxt = HFWD_DS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ds_r <= HFWD_DS_IDLE;
            ds_cnt_r <= 32'h0000_0000;
            ds_go_u3 <= 1'b0;
            ds_resume <= 1'b0;
            en_prev_r <= 1'b0;
        end else if (clk_en) begin
            ds_r <= ds_nxt;
            ds_cnt_r <= ds_cnt_nxt;
            ds_go_u3 <= go_u3_nxt;
            ds_resume <= resume_nxt;
            en_prev_r <= ds_enabled;
        end
    end
endmodule : hfwd_core
`default_nettype wire

// file: bench/hfwd_monitor.sv
`include "hfwd_cfg.svh"
`default_nettype none
module hfwd_monitor
#(parameter int DATA_W = 32, parameter int RESUME_CYC = 16) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clk_en,
    // Streams
    input wire logic rx_valid,
    input wire logic [DATA_W-1:0] rx_data,
    input wire logic rx_last,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [DATA_W-1:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_ready,
    // Power state, weight, mode
    input wire logic us_in_u3,
    input wire logic rwake_en,
    input wire logic ds_go_u3,
    input wire logic ds_resume,
    input wire logic [15:0] port_rate_10mbps,
    input wire logic [15:0] arb_weight,
    input wire logic host_enh_cap,
    input wire logic dev_enh_cap,
    input wire hfwd_pkg::hfwd_conn_t conn_mode,
    input wire logic [15:0] hub_delay_ns
);
    timeunit 1ns;
    timeprecision 100ps;
    import hfwd_pkg::*;
    logic [15:0] res_cnt_r;
    logic [15:0] res_cnt_nxt;
    logic [31:0] wt_full;
    logic [15:0] wt_sat;
    // Unsaturated product is kept wide so a fast port cannot wrap
    assign wt_full = {16'h0000, port_rate_10mbps} * 32'h0000_0100 / 32'h0000_007D;
    assign wt_sat = (wt_full > 32'h0000_FFFF) ? 16'hFFFF : wt_full[15:0];
    always_comb begin
        res_cnt_nxt = ds_resume ? res_cnt_r + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) res_cnt_r <= 16'h0000;
        else res_cnt_r <= res_cnt_nxt;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_fwd_next_cycle: assert property (rx_valid && rx_ready && clk_en && !tx_valid |=>
        tx_valid && tx_data == $past(rx_data) && tx_last == $past(rx_last))
        else $error("word not forwarded next cycle");
    a_tx_hold_stall: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("tx word lost in stall");
    a_go_u3_cause: assert property (ds_go_u3 |->
        $past(us_in_u3, 2) && !$past(rwake_en, 2) ##1 !ds_go_u3) else $error("bad U3 entry pulse");
    a_resume_length: assert property ($fell(ds_resume) |->
        res_cnt_r == 16'(RESUME_CYC + 1)) else $error("resume length wrong");
    a_weight_calc: assert property (clk_en |=> arb_weight == $past(wt_sat))
        else $error("arbitration weight wrong");
    a_conn_enh_mode: assert property ((host_enh_cap && dev_enh_cap) [*8] |->
        conn_mode == HFWD_CONN_ENH) else $error("enhanced mode missing");
    a_conn_legacy_mode: assert property ((!(host_enh_cap && dev_enh_cap)) [*8] |->
        conn_mode == HFWD_CONN_LEGACY) else $error("legacy mode missing");
    a_delay_report: assert property ($past(rstn) |->
        hub_delay_ns == 16'(`HFWD_ACTUAL_DELAY_NS)) else $error("reported delay wrong");
    c_stall: cover property (tx_valid && !tx_ready);
    c_go_u3: cover property (ds_go_u3);
    c_enh: cover property (conn_mode == HFWD_CONN_ENH);
endmodule : hfwd_monitor
bind hfwd_core hfwd_monitor #(.DATA_W(DATA_W), .RESUME_CYC(RESUME_CYC)) hfwd_monitor_i (
    .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .us_in_u3(us_in_u3),
    .rwake_en(rwake_en), .ds_go_u3(ds_go_u3), .ds_resume(ds_resume),
    .port_rate_10mbps(port_rate_10mbps), .arb_weight(arb_weight),
    .host_enh_cap(host_enh_cap), .dev_enh_cap(dev_enh_cap), .conn_mode(conn_mode),
    .hub_delay_ns(hub_delay_ns));
`default_nettype wire

// file: bench/hfwd_sink.sv
`default_nettype none
module hfwd_sink (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Mode: 0 random stalls, 1 always ready, 2 stalled
    input wire logic [1:0] mode,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] lfsr;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lfsr <= 16'hACE1;
            tx_ready <= 1'b0;
        end else begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            tx_ready <= #1 (mode == 2'd1) || (mode == 2'd0 && lfsr[0]);
        end
    end
endmodule : hfwd_sink
`default_nettype wire

// file: bench/hub_forwarding_timing_bench.sv
`default_nettype none
module hub_forwarding_timing_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import hfwd_pkg::*;
    logic core_clk, rstn, clk_en, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
    logic same_speed, links_u0, lcmd_pending, credit_nonzero, txbuf_empty, ds_enabled;
    logic us_in_u3, rwake_en, u0_request, ds_go_u3, ds_resume, host_enh_cap, dev_enh_cap;
    logic fwd_in_bound;
    logic [31:0] rx_data, tx_data, seed, e;
    logic [15:0] port_rate_10mbps, arb_weight, hub_delay_ns;
    logic [1:0] mode;
    hfwd_conn_t conn_mode;
    logic [32:0] exp_q[$];
    int err_total = 0, tests_run = 0, gos = 0, ress = 0, cyc = 0;
    hfwd_core #(.DATA_W(32), .EN_U3_CYC(16), .RESUME_CYC(16)) hfwd_core_i (
        .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
        .same_speed(same_speed), .links_u0(links_u0), .lcmd_pending(lcmd_pending),
        .credit_nonzero(credit_nonzero), .txbuf_empty(txbuf_empty),
        .ds_enabled(ds_enabled), .us_in_u3(us_in_u3), .rwake_en(rwake_en),
        .u0_request(u0_request), .ds_go_u3(ds_go_u3), .ds_resume(ds_resume),
        .port_rate_10mbps(port_rate_10mbps), .arb_weight(arb_weight),
        .host_enh_cap(host_enh_cap), .dev_enh_cap(dev_enh_cap), .conn_mode(conn_mode),
        .hub_delay_ns(hub_delay_ns), .fwd_in_bound(fwd_in_bound));
    hfwd_sink hfwd_sink_i (.core_clk(core_clk), .rstn(rstn), .mode(mode), .tx_ready(tx_ready));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task chk_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val
    task chk_word(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word
    task results;
        $display("errors=%0d checks=%0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    task step;
        @(posedge core_clk);
        #1;
    endtask : step
    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    // Reference model of the two-entry path: words leave in arrival order
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            results;
        end
        if (rstn && tx_valid && tx_ready) begin
            chk_word({tx_last, tx_data}, exp_q.size() ? exp_q.pop_front() : 33'h0);
        end
        if (rstn && rx_valid && rx_ready && clk_en) exp_q.push_back({rx_last, rx_data});
        if (ds_go_u3) gos++;
        if (ds_resume) ress++;
    end
    initial begin
        {rstn, rx_valid, rx_data, rx_last, lcmd_pending, ds_enabled, us_in_u3} = '0;
        {rwake_en, u0_request, port_rate_10mbps, host_enh_cap, dev_enh_cap, mode} = '0;
        {clk_en, same_speed, links_u0, credit_nonzero, txbuf_empty} = 5'h1F;
        seed = 32'h1265_a855;
        repeat (2) @(posedge core_clk);
        #1 rstn = 1;
        step;
        step;
        chk_val(hub_delay_ns, 32'h0000_001E);
        repeat (300) begin
            seed = xs(seed);
            {rx_valid, rx_last} = seed[1:0];
            rx_data = seed;
            mode = seed[3] ? 2'd1 : 2'd0;
            step;
        end
        {rx_valid, rx_last, lcmd_pending, mode} = 5'h1E;
        repeat (6) step;
        chk_val(rx_ready, 0);
        rx_valid = 0;
        repeat (60) step;
        chk_val(fwd_in_bound, 1);
        lcmd_pending = 0;
        repeat (60) step;
        chk_val(fwd_in_bound, 0);
        mode = 1;
        repeat (10) step;
        chk_val(exp_q.size(), 0);
        repeat (20) begin
            seed = xs(seed);
            {rx_valid, rx_data} = {1'b1, seed};
            step;
        end
        rx_valid = 0;
        repeat (3) step;
        chk_val(fwd_in_bound, 1);
        {us_in_u3, rwake_en, ds_enabled} = 3'b111;
        repeat (10) step;
        chk_val(gos, 0);
        {rwake_en, ds_enabled} = 2'b00;
        repeat (2) step;
        ds_enabled = 1;
        repeat (10) step;
        chk_val(gos, 1);
        u0_request = 1;
        step;
        u0_request = 0;
        repeat (40) step;
        chk_val(ress, 17);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            port_rate_10mbps = (i < 3) ? 16'(i * 125) : (i == 3 ? 16'hFFFF : seed[15:0]);
            e = {16'h0000, port_rate_10mbps} * 256 / 125;
            repeat (2) step;
            chk_val(arb_weight, (e > 32'h0000_FFFF) ? 32'h0000_FFFF : e);
        end
        for (int i = 0; i < 4; i++) begin
            {host_enh_cap, dev_enh_cap} = 2'(i);
            repeat (10) step;
            chk_val(conn_mode, (i == 3) ? HFWD_CONN_ENH : HFWD_CONN_LEGACY);
        end
        results;
    end
endmodule : hub_forwarding_timing_bench
`default_nettype wire
